// ==== common/flag_xfer_defines.svh ====
// Purpose: named offsets, encodings and field positions for the executor
// Assumes: 12-bit apb byte address, 16-bit instruction words
// Notes: definitions only
`ifndef FLAG_XFER_DEFINES_SVH
`define FLAG_XFER_DEFINES_SVH

// ************************************
// register offsets
// ************************************
`define OFF_INSTR 12'h000
`define OFF_EXT 12'h004
`define OFF_PC 12'h008
`define OFF_SREG 12'h00C
`define OFF_REGIDX 12'h010
`define OFF_REGDATA 12'h014
`define OFF_STATUS 12'h018

// ************************************
// opcode patterns
// ************************************
`define BRB_MASK 16'hF800
`define BRB_VAL 16'hF000
`define MOV_MASK 16'hFC00
`define MOV_VAL 16'h2C00
`define REGISTER_PAIR_COPY_MASK 16'hFF00
`define REGISTER_PAIR_COPY_VAL 16'h0100
`define LDI_MASK 16'hF000
`define LDI_VAL 16'hE000
`define LDST_MASK 16'hFC00
`define LDST_VAL 16'h9000
`define LDD_MASK 16'hD000
`define LDD_VAL 16'h8000
`define LPM_R0 16'h95C8

// ************************************
// addressing mode nibble
// ************************************
`define NIB_DIR 4'h0
`define NIB_ZINC 4'h1
`define NIB_ZDEC 4'h2
`define NIB_PMZ 4'h4
`define NIB_PMZINC 4'h5
`define NIB_YINC 4'h9
`define NIB_YDEC 4'hA
`define NIB_X 4'hC
`define NIB_XINC 4'hD
`define NIB_XDEC 4'hE

// ************************************
// register file positions and small constants
// ************************************
`define PTR_X 5'h1A
`define PTR_Y 5'h1C
`define PTR_Z 5'h1E
`define REG_R0 5'h00
`define LDI_BASE 5'h10
`define ONE16 16'h0001
`define TWO16 16'h0002
`define CYC_ONE 2'h1

`endif

// ==== common/flag_xfer_pkg.sv ====
// Purpose: types shared by the executor
// Assumes: nothing beyond the defines header
// Notes: all module state lives in one packed struct
package flag_xfer_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_BR2, ST_MEM2, ST_PM2, ST_PM3} exec_state_t;

  typedef struct packed {
    exec_state_t st;
    logic [15:0] instr;
    logic [15:0] ext;
    logic [15:0] pc;
    logic [7:0] sreg;
    logic [31:0][7:0] rf;
    logic [4:0] regIdx;
    logic [4:0] dst;
    logic [1:0] cyc;
    logic [31:0] prdata;
    logic [15:0] dmAddr;
    logic [7:0] dmWrData;
    logic dmWe;
    logic dmRe;
    logic [14:0] pmAddr;
    logic pmRe;
    logic pmHi;
  } core_state_t;

endpackage : flag_xfer_pkg

// ==== hdl/flag_xfer_exec.sv ====
// Purpose: executes flag branches and data transfer instructions issued over apb
// Assumes: data memory reads combinationally; program memory has one cycle latency
// Notes: busy instructions refuse apb writes to core state
// Function
// - transfer flag clear: pc gets pc plus offset plus one, 1/2 cycles
// - overflow set: relative branch, 1/2 cycles, no flag change
// - overflow clear: relative branch, 1/2 cycles, no flag change
// - interrupt enable set: relative branch, 1/2 cycles, flags untouched
// - interrupt enable clear: relative branch, 1/2 cycles, flags untouched
// - indirect load through X, Y, Z, optional post increment, 2 cycles
// - pre-decrement load: decrement pointer, then read, 2 cycles
// - displaced load at Y or Z plus q, pointer kept, 2 cycles
// - direct load from instruction address, 2 cycles, no flags
// - indirect store through X, Y, Z, optional post increment, 2 cycles
// - pre-decrement store: decrement pointer, then write, 2 cycles
// - displaced store at Y or Z plus q, pointer kept, 2 cycles
// - direct store to instruction address, 2 cycles, no flags
// - program memory byte at Z into r0 or Rd, optional Z+, 3 cycles
`timescale 1ns/1ps
`include "flag_xfer_defines.svh"

module flag_xfer_exec (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] dmAddr,
  output logic [7:0] dmWrData,
  output logic dmWe,
  output logic dmRe,
  input wire logic [7:0] dmRdData,
  output logic [14:0] pmAddr,
  output logic pmRe,
  input wire logic [15:0] pmRdData,
  output logic busy
);
  import flag_xfer_pkg::*;

  // ************************************
  // state
  // ************************************
  core_state_t s_q;
  core_state_t s_d;

  logic [15:0] op;
  logic [3:0] nib;
  logic isBrb;
  logic isMov;
  logic isMovw;
  logic isLdi;
  logic isLdst;
  logic isLdd;
  logic isLpm0;
  logic isStore;
  logic [4:0] rd;
  logic [4:0] rr;
  logic [4:0] ptrSel;
  logic [15:0] ptrVal;
  logic [15:0] disp;
  logic [15:0] brOff;
  logic brTaken;
  logic accWr;
  logic accRd;
  logic mapped;
  logic [31:0] rdMux;
  logic ptrForm;

  function automatic logic [15:0] pairGet(input logic [31:0][7:0] rf, input logic [4:0] i);
    pairGet = {rf[i + 5'h01], rf[i]};
  endfunction : pairGet

  // ************************************
  // decode
  // ************************************
  always_comb begin
    op = s_q.instr;
    nib = op[3:0];
    rd = op[8:4];
    rr = {op[9], op[3:0]};
    isBrb = (op & `BRB_MASK) == `BRB_VAL;
    isMov = (op & `MOV_MASK) == `MOV_VAL;
    isMovw = (op & `REGISTER_PAIR_COPY_MASK) == `REGISTER_PAIR_COPY_VAL;
    isLdi = (op & `LDI_MASK) == `LDI_VAL;
    isLdst = (op & `LDST_MASK) == `LDST_VAL;
    isLdd = (op & `LDD_MASK) == `LDD_VAL;
    isLpm0 = op == `LPM_R0;
    isStore = op[9];
    // nibbles with a pointer or direct form
    ptrForm = nib == `NIB_DIR || nib == `NIB_ZINC || nib == `NIB_ZDEC || nib == `NIB_YINC ||
              nib == `NIB_YDEC || nib == `NIB_X || nib == `NIB_XINC || nib == `NIB_XDEC;
    disp = {10'h000, op[13], op[11:10], op[2:0]};
    brOff = {{9{op[9]}}, op[9:3]};
    if (isLdd) begin
      ptrSel = op[3] ? `PTR_Y : `PTR_Z;
    end else if (nib == `NIB_X || nib == `NIB_XINC || nib == `NIB_XDEC) begin
      ptrSel = `PTR_X;
    end else if (nib == `NIB_YINC || nib == `NIB_YDEC) begin
      ptrSel = `PTR_Y;
    end else begin
      ptrSel = `PTR_Z;
    end
    ptrVal = pairGet(s_q.rf, ptrSel);
    brTaken = s_q.sreg[op[2:0]] != op[10];
  end

  // ************************************
  // apb slave
  // ************************************
  always_comb begin
    mapped = paddr == `OFF_INSTR || paddr == `OFF_EXT || paddr == `OFF_PC ||
             paddr == `OFF_SREG || paddr == `OFF_REGIDX || paddr == `OFF_REGDATA ||
             paddr == `OFF_STATUS;
    accWr = psel && penable && pwrite && mapped && s_q.st == ST_IDLE;
    accRd = psel && !penable && !pwrite;
    if (paddr == `OFF_INSTR) begin
      rdMux = {16'h0000, s_q.instr};
    end else if (paddr == `OFF_EXT) begin
      rdMux = {16'h0000, s_q.ext};
    end else if (paddr == `OFF_PC) begin
      rdMux = {16'h0000, s_q.pc};
    end else if (paddr == `OFF_SREG) begin
      rdMux = {24'h00_0000, s_q.sreg};
    end else if (paddr == `OFF_REGIDX) begin
      rdMux = {27'h000_0000, s_q.regIdx};
    end else if (paddr == `OFF_REGDATA) begin
      rdMux = {24'h00_0000, s_q.rf[s_q.regIdx]};
    end else if (paddr == `OFF_STATUS) begin
      rdMux = {29'h0000_0000, s_q.cyc, s_q.st != ST_IDLE};
    end else begin
      rdMux = 32'h0000_0000;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_q.prdata;
  assign dmAddr = s_q.dmAddr;
  assign dmWrData = s_q.dmWrData;
  assign dmWe = s_q.dmWe;
  assign dmRe = s_q.dmRe;
  assign pmAddr = s_q.pmAddr;
  assign pmRe = s_q.pmRe;
  assign busy = s_q.st != ST_IDLE;

  // ************************************
  // next state
  // ************************************
  always_comb begin
    s_d = s_q;
    s_d.dmWe = 1'b0;
    s_d.dmRe = 1'b0;
    s_d.pmRe = 1'b0;
    if (accRd) begin
      s_d.prdata = rdMux;
    end
    if (accWr) begin
      if (paddr == `OFF_INSTR) begin
        s_d.instr = pwdata[15:0];
        s_d.st = ST_EXEC;
        s_d.cyc = 2'h0;
      end else if (paddr == `OFF_EXT) begin
        s_d.ext = pwdata[15:0];
      end else if (paddr == `OFF_PC) begin
        s_d.pc = pwdata[15:0];
      end else if (paddr == `OFF_SREG) begin
        s_d.sreg = pwdata[7:0];
      end else if (paddr == `OFF_REGIDX) begin
        s_d.regIdx = pwdata[4:0];
      end else if (paddr == `OFF_REGDATA) begin
        s_d.rf[s_q.regIdx] = pwdata[7:0];
      end
    end
    case (s_q.st)
      ST_IDLE: begin
        // keeps a start taken from the bus
      end
      ST_EXEC: begin
        s_d.cyc = `CYC_ONE;
        s_d.st = ST_IDLE;
        s_d.pc = s_q.pc + `ONE16;
        s_d.dst = rd;
        if (isBrb) begin
          if (brTaken) begin
            s_d.st = ST_BR2;
          end
        end else if (isMov) begin
          s_d.rf[rd] = s_q.rf[rr];
        end else if (isMovw) begin
          s_d.rf[{op[7:4], 1'b0}] = s_q.rf[{op[3:0], 1'b0}];
          s_d.rf[{op[7:4], 1'b1}] = s_q.rf[{op[3:0], 1'b1}];
        end else if (isLdi) begin
          s_d.rf[`LDI_BASE + {1'b0, op[7:4]}] = {op[11:8], op[3:0]};
        end else if (isLpm0 || (isLdst && !isStore &&
                     (nib == `NIB_PMZ || nib == `NIB_PMZINC))) begin
          s_d.dst = isLpm0 ? `REG_R0 : rd;
          s_d.pmAddr = ptrVal[15:1];
          s_d.pmHi = ptrVal[0];
          s_d.pmRe = 1'b1;
          s_d.st = ST_PM2;
          if (!isLpm0 && nib == `NIB_PMZINC) begin
            {s_d.rf[`PTR_Z + 5'h01], s_d.rf[`PTR_Z]} = ptrVal + `ONE16;
          end
        end else if (isLdd || (isLdst && ptrForm)) begin
          // other nibbles fall through as no-ops
          s_d.st = ST_MEM2;
          s_d.dmRe = !isStore;
          s_d.dmWe = isStore;
          s_d.dmWrData = s_q.rf[rd];
          if (isLdd) begin
            s_d.dmAddr = ptrVal + disp;
          end else if (nib == `NIB_DIR) begin
            s_d.dmAddr = s_q.ext;
            s_d.pc = s_q.pc + `TWO16;
          end else if (nib == `NIB_ZDEC || nib == `NIB_YDEC || nib == `NIB_XDEC) begin
            s_d.dmAddr = ptrVal - `ONE16;
            {s_d.rf[ptrSel + 5'h01], s_d.rf[ptrSel]} = ptrVal - `ONE16;
          end else begin
            s_d.dmAddr = ptrVal;
            if (nib == `NIB_ZINC || nib == `NIB_YINC || nib == `NIB_XINC) begin
              {s_d.rf[ptrSel + 5'h01], s_d.rf[ptrSel]} = ptrVal + `ONE16;
            end
          end
        end
      end
      ST_BR2: begin
        s_d.pc = s_q.pc + brOff;
        s_d.cyc = s_q.cyc + `CYC_ONE;
        s_d.st = ST_IDLE;
      end
      ST_MEM2: begin
        if (!isStore || isLdd) begin
          if (s_q.dmRe) begin
            s_d.rf[s_q.dst] = dmRdData;
          end
        end
        s_d.cyc = s_q.cyc + `CYC_ONE;
        s_d.st = ST_IDLE;
      end
      ST_PM2: begin
        s_d.cyc = s_q.cyc + `CYC_ONE;
        s_d.st = ST_PM3;
      end
      ST_PM3: begin
        s_d.rf[s_q.dst] = s_q.pmHi ? pmRdData[15:8] : pmRdData[7:0];
        s_d.cyc = s_q.cyc + `CYC_ONE;
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // ************************************
  // registers
  // ************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : flag_xfer_exec

// ==== test/flag_xfer_exec_asserts.sv ====
// Purpose: port level checks of the executor timing
// Assumes: one clock, synchronous active high reset
// Notes: bound into every executor instance
`timescale 1ns/1ps
`include "flag_xfer_defines.svh"

module flag_xfer_exec_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic dmWe,
  input wire logic dmRe,
  input wire logic pmRe,
  input wire logic busy
);
  // ************************************
  // instruction issue and properties
  // ************************************
  logic go;
  assign go = psel && penable && pwrite && (paddr == `OFF_INSTR) && !busy;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  br_cycles_a: assert property (
    go && ((pwdata[15:0] & `BRB_MASK) == `BRB_VAL) |=> busy ##[1:2] !busy)
    else $error("branch busy length wrong");
  ldi_cycles_a: assert property (
    go && ((pwdata[15:0] & `LDI_MASK) == `LDI_VAL) |=> busy ##1 !busy)
    else $error("immediate load not one cycle");
  mov_cycles_a: assert property (
    go && ((pwdata[15:0] & `MOV_MASK) == `MOV_VAL) |=> busy ##1 !busy)
    else $error("register copy not one cycle");
  load_second_a: assert property (
    dmRe |-> busy && $past(busy) && !dmWe)
    else $error("read strobe outside second cycle");
  load_end_a: assert property (
    dmRe |=> !busy)
    else $error("load longer than two cycles");
  store_end_a: assert property (
    dmWe |-> $past(busy) ##1 !busy)
    else $error("store not two cycles");
  first_quiet_a: assert property (
    $rose(busy) |-> !dmRe && !dmWe && !pmRe)
    else $error("memory strobe in first cycle");
  pm_third_a: assert property (
    pmRe |-> $past(busy) ##1 busy ##1 !busy)
    else $error("program read not three cycles");
  busy_bound_a: assert property (
    $rose(busy) |-> ##[1:3] !busy)
    else $error("busy held too long");
endmodule : flag_xfer_exec_asserts

bind flag_xfer_exec flag_xfer_exec_asserts i_flag_xfer_exec_asserts (
  .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .dmWe, .dmRe, .pmRe, .busy
);

// ==== test/flag_xfer_mem.sv ====
// Purpose: behavioural data and program memory
// Assumes: combinational data read, one cycle program read
// Notes: idle read lines show scrambled values
`timescale 1ns/1ps

module flag_xfer_mem (
  input wire logic clk_sys,
  input wire logic [15:0] dmAddr,
  input wire logic [7:0] dmWrData,
  input wire logic dmWe,
  input wire logic dmRe,
  output logic [7:0] dmRdData,
  input wire logic [14:0] pmAddr,
  input wire logic pmRe,
  output logic [15:0] pmRdData
);
  // ************************************
  // storage
  // ************************************
  logic [7:0] mem [0:255];
  logic [7:0] lastRd;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h33;
    lastRd = 8'h00;
    pmRdData = 16'h0000;
  end
  assign dmRdData = dmRe ? mem[dmAddr[7:0]] : ~lastRd;
  always @(posedge clk_sys) begin
    if (dmWe) mem[dmAddr[7:0]] <= dmWrData;
    if (dmRe) lastRd <= mem[dmAddr[7:0]];
    pmRdData <= pmRe ? {pmAddr[7:0] ^ 8'hA5, pmAddr[7:0]} : ~pmRdData;
  end
endmodule : flag_xfer_mem

// ==== test/testbench.sv ====
// Purpose: apb driven tests of branches and transfers
// Assumes: zero wait apb slave, memories from partner model
// Notes: expectations computed here
`timescale 1ns/1ps
`include "flag_xfer_defines.svh"

module testbench;
  import flag_xfer_pkg::*;
  logic clk_sys = 1'b0, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, s;
  logic [15:0] dmAddr, pmRdData;
  logic [14:0] pmAddr;
  logic [7:0] dmWrData, dmRdData, a, sv;
  logic dmWe, dmRe, pmRe, busy, tk;
  int n_fail = 0, checks = 0;
  int fb[5] = '{6, 3, 3, 7, 7};
  int fc[5] = '{1, 0, 1, 0, 1};
  logic [15:0] mo[11] = '{16'h904C, 16'h904D, 16'h904E, 16'h9049, 16'h904A, 16'h804D,
    16'h9041, 16'h9042, 16'h8045, 16'h8040, 16'h9040};
  int rg[11] = '{26, 26, 26, 28, 28, 28, 30, 30, 30, 30, 30};
  int ao[11] = '{0, 0, -1, 0, -1, 5, 0, -1, 5, 0, 7};
  int po[11] = '{0, 1, -1, 1, -1, 0, 1, -1, 0, 0, 0};
  logic [15:0] lo[3] = '{16'h95C8, 16'h9045, 16'h9044};
  int ld[3] = '{0, 4, 4};
  logic [7:0] lz[3] = '{8'h13, 8'h13, 8'h14};
  logic [7:0] ln[3] = '{8'h13, 8'h14, 8'h14};
  always #5 clk_sys = ~clk_sys;
  flag_xfer_exec i_flag_xfer_exec (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dmAddr, .dmWrData, .dmWe, .dmRe, .dmRdData,
    .pmAddr, .pmRe, .pmRdData, .busy);
  flag_xfer_mem i_flag_xfer_mem (.clk_sys, .dmAddr, .dmWrData, .dmWe, .dmRe, .dmRdData,
    .pmAddr, .pmRe, .pmRdData);
  // ************************************
  // tasks
  // ************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic hang;
    n_fail++;
    end_of_test();
  endtask : hang
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
    output logic [31:0] rd);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 16) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic setr(input int r, input logic [7:0] v);
    apb(1'b1, `OFF_REGIDX, r, q);
    apb(1'b1, `OFF_REGDATA, {24'h00_0000, v}, q);
  endtask : setr
  task automatic getr(input int r);
    apb(1'b1, `OFF_REGIDX, r, q);
    apb(1'b0, `OFF_REGDATA, 32'h0000_0000, q);
  endtask : getr
  task automatic ex(input logic [15:0] op, output logic [31:0] st);
    int i;
    apb(1'b1, `OFF_INSTR, {16'h0000, op}, st);
    for (i = 0; i < 20; i++) begin
      apb(1'b0, `OFF_STATUS, 32'h0000_0000, st);
      if (st[0] === 1'b0) break;
    end
    if (i == 20) hang();
  endtask : ex
  // ************************************
  // sequence
  // ************************************
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0000_0000};
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, `OFF_PC, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      sv = (i % 2) ? 8'h01 << fb[i / 2] : ~(8'h01 << fb[i / 2]);
      tk = (i % 2) != fc[i / 2];
      apb(1'b1, `OFF_SREG, {24'h00_0000, sv}, q);
      apb(1'b1, `OFF_PC, 32'h0000_0010, q);
      ex(16'hF3E8 | 16'(fc[i / 2] << 10) | 16'(fb[i / 2]), s);
      chk(s, tk ? 32'h0000_0004 : 32'h0000_0002);
      apb(1'b0, `OFF_PC, 32'h0000_0000, q);
      chk(q, tk ? 32'h0000_000E : 32'h0000_0011);
      apb(1'b0, `OFF_SREG, 32'h0000_0000, q);
      chk(q, {24'h00_0000, sv});
    end
    setr(17, 8'h3C);
    ex(16'hE50A, s);
    chk(s, 32'h0000_0002);
    ex(16'h2E50, s);
    ex(16'h0118, s);
    getr(5);
    chk(q, 32'h0000_005A);
    getr(3);
    chk(q, 32'h0000_003C);
    for (int i = 0; i < 11; i++) begin
      a = 8'(64 + ao[i]);
      setr(rg[i], 8'h40);
      setr(rg[i] + 1, 8'h00);
      apb(1'b1, `OFF_EXT, 32'h0000_0047, q);
      ex(mo[i], s);
      chk(s, 32'h0000_0004);
      getr(4);
      chk(q, {24'h00_0000, a ^ 8'h33});
      getr(rg[i]);
      chk(q, 32'(64 + po[i]));
      setr(rg[i], 8'h40);
      i_flag_xfer_mem.mem[a] = 8'h00;
      ex(mo[i] | 16'h0200, s);
      chk(s, 32'h0000_0004);
      chk({24'h00_0000, i_flag_xfer_mem.mem[a]}, {24'h00_0000, a ^ 8'h33});
      getr(rg[i]);
      chk(q, 32'(64 + po[i]));
    end
    setr(30, 8'h13);
    setr(31, 8'h00);
    for (int i = 0; i < 3; i++) begin
      ex(lo[i], s);
      chk(s, 32'h0000_0006);
      getr(ld[i]);
      a = {1'b0, lz[i][7:1]};
      chk(q, {24'h00_0000, lz[i][0] ? a ^ 8'hA5 : a});
      getr(30);
      chk(q, {24'h00_0000, ln[i]});
    end
    apb(1'b0, 12'h01C, 32'h0000_0000, q);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    end_of_test();
  end
endmodule : testbench
